// [rtl/lowside_lane_config.sv]
// Purpose: Low-side lane configuration registers behind an Avalon-MM slave
// Assumes: 125 MHz clk, power-down pin asynchronous to clk
// Notes: Four lanes share one register window steered by the lane mask
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Multiplier codes decode to factors, some reserved
// - Bits 14:12 swing code, reset 101
// - Swing codes map monotonically 190 to 1050 mV
// - Bit 11 enables loss-of-signal detect, reset one
// - Bit 10 enables transmit lane, reset one
// - Power-down pin or global bit kills transmit
// - Bits 9:8 transmit rate, full/half/quarter
// - Rate fields used only under override
// - Bits 7:4 de-emphasis code, reset zero
// - Bit 2 receive enable, power-down overrides it
// - Bits 1:0 receive rate, same encoding
// - Register at index 7, reset DC04
// - Lane mask steers writes, selects read lane
// - Multiplier resets 0101, used only under override
module lowside_lane_config (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic channel_powerdown_n,
   output logic [3:0] tx_lane_enable,
   output logic [3:0] rx_lane_enable,
   output logic [3:0] signal_loss_detect_enable,
   output logic [7:0] tx_lane_rate,
   output logic [7:0] rx_lane_rate,
   output logic [11:0] output_amplitude_code,
   output logic [15:0] deemphasis_code,
   output logic [43:0] output_amplitude_mv,
   output logic [43:0] deemphasis_cdb,
   output logic [3:0] pll_multiplier_code,
   output logic pll_enable,
   output logic [7:0] pll_factor_x2,
   output logic pll_code_reserved
);
   localparam int L = lane_cfg_pkg::NUM_LANES;

   typedef struct packed {
      lane_cfg_pkg::bus_state_t st;
      logic waitreq;
      logic [31:0] rdata;
      logic pd_meta;
      logic pd_sync;
      logic [1:0] ctrl;
      logic [15:0] pll_cfg;
      logic [3:0] tx_en;
      logic [3:0] rx_en;
      logic [7:0] tx_rate;
      logic [7:0] rx_rate;
      logic [3:0] pll_code;
      logic pll_en;
   } state_t;

   state_t q;
   state_t d;

   logic [L*16-1:0] lane_words;
   logic [15:0] lane_rdata;
   logic [L-1:0] lane_we;
   logic [1:0] rd_lane;
   logic [3:0] lane_mask;
   logic powered;
   logic override;
   logic hit_lane;
   logic hit_pll;
   logic hit_ctrl;
   logic hit_status;

   // Bus decode
   logic in_work;
   logic wr_lane;
   logic wr_pll;
   logic wr_ctrl;
   logic rd_now;
   logic pd_active;
   logic [15:0] pll_wr_word;
   logic [1:0] ctrl_wr_word;
   logic [31:0] lane_rd_word;
   logic [31:0] pll_rd_word;
   logic [31:0] ctrl_rd_word;
   logic [31:0] status_word;

   // Per-lane fields pulled out of the stored words
   logic [L-1:0] lane_tx_bit;
   logic [L-1:0] lane_rx_bit;
   logic [2*L-1:0] lane_tx_rate;
   logic [2*L-1:0] lane_rx_rate;

   // Lowest selected lane answers reads; an empty mask falls back to lane 0
   function automatic logic [1:0] first_lane(input logic [3:0] m);
      logic [1:0] r;
      r = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (m[i]) begin
            r = 2'(i);
         end
      end
      return r;
   endfunction

   assign lane_mask = q.pll_cfg[lane_cfg_pkg::MASK_LSB +: 4];
   assign rd_lane = first_lane(lane_mask);
   assign hit_lane = (address == lane_cfg_pkg::LANE_CFG_ADDR);
   assign hit_pll = (address == lane_cfg_pkg::PLL_CFG_ADDR);
   assign hit_ctrl = (address == lane_cfg_pkg::CTRL_ADDR);
   assign hit_status = (address == lane_cfg_pkg::STATUS_ADDR);
   assign powered = q.pd_sync && !q.ctrl[lane_cfg_pkg::CTRL_GPD_BIT];
   assign override = q.ctrl[lane_cfg_pkg::CTRL_OVR_BIT];

   // Requests act only in the work state, while the master still holds them
   assign in_work = (q.st == lane_cfg_pkg::BUS_WORK);
   assign wr_lane = in_work && write && hit_lane;
   assign wr_pll = in_work && write && hit_pll;
   assign wr_ctrl = in_work && write && hit_ctrl && byteenable[0];
   assign rd_now = in_work && read;

   // Writes land on every lane whose mask bit is set
   assign lane_we = wr_lane ? lane_mask : 4'h0;

   // Unselected byte lanes keep their stored value
   assign pll_wr_word[7:0] = byteenable[0] ? writedata[7:0] : q.pll_cfg[7:0];
   assign pll_wr_word[15:8] = byteenable[1] ? writedata[15:8] : q.pll_cfg[15:8];
   assign ctrl_wr_word = writedata[1:0];

   // Read words
   assign lane_rd_word = {16'h0000, lane_rdata};
   assign pll_rd_word = {16'h0000, q.pll_cfg};
   assign ctrl_rd_word = {30'h0000_0000, q.ctrl};

   // Status shows synchronised state only, never the raw pin
   assign pd_active = !q.pd_sync;
   assign status_word[3:0] = q.tx_en;
   assign status_word[7:4] = q.rx_en;
   assign status_word[8] = override;
   assign status_word[9] = pd_active;
   assign status_word[10] = pll_code_reserved;
   assign status_word[31:11] = 21'h00_0000;

   lane_store #(
      .LANES(L),
      .W(16),
      .RST(lane_cfg_pkg::LANE_CFG_RST)
   ) u_store (
      .clk(clk),
      .rstn(rstn),
      .we_lanes(lane_we),
      .be(byteenable[1:0]),
      .wdata(writedata[15:0]),
      .rd_lane(rd_lane),
      .words(lane_words),
      .rdata_q(lane_rdata)
   );

   genvar g;
   generate
      for (g = 0; g < L; g++) begin : g_lane
         logic [7:0] x2;
         logic rsvd;
         code_tables u_tab (
            .clk(clk),
            .rstn(rstn),
            .swing(lane_words[g*16 + lane_cfg_pkg::SWING_LSB +: 3]),
            .deemph(lane_words[g*16 + lane_cfg_pkg::DE_LSB +: 4]),
            .pll_code(q.pll_code),
            .amp_mv(output_amplitude_mv[g*11 +: 11]),
            .deemph_cdb(deemphasis_cdb[g*11 +: 11]),
            .pll_x2(x2),
            .pll_rsvd(rsvd)
         );
         if (g == 0) begin : g_pll
            assign pll_factor_x2 = x2;
            assign pll_code_reserved = rsvd;
         end
         assign signal_loss_detect_enable[g] =
            lane_words[g*16 + lane_cfg_pkg::LOS_BIT];
         assign output_amplitude_code[g*3 +: 3] =
            lane_words[g*16 + lane_cfg_pkg::SWING_LSB +: 3];
         assign deemphasis_code[g*4 +: 4] =
            lane_words[g*16 + lane_cfg_pkg::DE_LSB +: 4];
         // Raw fields; power-down and override apply in the state logic
         assign lane_tx_bit[g] = lane_words[g*16 + lane_cfg_pkg::TXEN_BIT];
         assign lane_rx_bit[g] = lane_words[g*16 + lane_cfg_pkg::RXEN_BIT];
         assign lane_tx_rate[g*2 +: 2] = lane_words[g*16 + lane_cfg_pkg::TXRATE_LSB +: 2];
         assign lane_rx_rate[g*2 +: 2] = lane_words[g*16 + lane_cfg_pkg::RXRATE_LSB +: 2];
      end
   endgenerate

   always_comb begin
      logic [31:0] rd;
      rd = 32'h0000_0000;
      d = q;

      // Pin passes two flops before use
      d.pd_meta = channel_powerdown_n;
      d.pd_sync = q.pd_meta;

      // Effective lane controls
      for (int i = 0; i < L; i++) begin
         d.tx_en[i] = lane_tx_bit[i] && powered;
         d.rx_en[i] = lane_rx_bit[i] && powered;
         if (override) begin
            d.tx_rate[i*2 +: 2] = lane_tx_rate[i*2 +: 2];
            d.rx_rate[i*2 +: 2] = lane_rx_rate[i*2 +: 2];
         end else begin
            d.tx_rate[i*2 +: 2] = lane_cfg_pkg::AUTO_RATE;
            d.rx_rate[i*2 +: 2] = lane_cfg_pkg::AUTO_RATE;
         end
      end
      if (override) begin
         d.pll_code = q.pll_cfg[lane_cfg_pkg::MPY_LSB +: 4];
      end else begin
         d.pll_code = lane_cfg_pkg::AUTO_PLL_CODE;
      end
      // PLL shares the lanes' power-down
      d.pll_en = q.pll_cfg[lane_cfg_pkg::PLLEN_BIT] && powered;

      // Read data for the current address
      if (hit_lane) begin
         rd = lane_rd_word;
      end else if (hit_pll) begin
         rd = pll_rd_word;
      end else if (hit_ctrl) begin
         rd = ctrl_rd_word;
      end else if (hit_status) begin
         rd = status_word;
      end else begin
         rd = 32'h0000_0000;
      end

      // Fixed two-edge answer keeps read data registered
      case (q.st)
         lane_cfg_pkg::BUS_IDLE: begin
            d.waitreq = 1'b1;
            if (read || write) begin
               d.st = lane_cfg_pkg::BUS_WORK;
            end
         end
         lane_cfg_pkg::BUS_WORK: begin
            d.st = lane_cfg_pkg::BUS_DONE;
            d.waitreq = 1'b0;
            // Acting here is safe: the master holds the request until waitrequest drops
            if (rd_now) begin
               d.rdata = rd;
            end
            if (wr_pll) begin
               d.pll_cfg = pll_wr_word;
            end
            if (wr_ctrl) begin
               d.ctrl = ctrl_wr_word;
            end
         end
         lane_cfg_pkg::BUS_DONE: begin
            d.st = lane_cfg_pkg::BUS_IDLE;
            d.waitreq = 1'b1;
         end
         default: begin
            d.st = lane_cfg_pkg::BUS_IDLE;
            d.waitreq = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q.st <= lane_cfg_pkg::BUS_IDLE;
         q.waitreq <= 1'b1;
         q.rdata <= 32'h0000_0000;
         q.pd_meta <= 1'b0;
         q.pd_sync <= 1'b0;
         q.ctrl <= lane_cfg_pkg::CTRL_RST;
         q.pll_cfg <= lane_cfg_pkg::PLL_CFG_RST;
         q.tx_en <= 4'h0;
         q.rx_en <= 4'h0;
         q.tx_rate <= 8'h00;
         q.rx_rate <= 8'h00;
         q.pll_code <= lane_cfg_pkg::AUTO_PLL_CODE;
         q.pll_en <= 1'b0;
      end else begin
         q <= d;
      end
   end

   assign readdata = q.rdata;
   assign waitrequest = q.waitreq;
   assign tx_lane_enable = q.tx_en;
   assign rx_lane_enable = q.rx_en;
   assign tx_lane_rate = q.tx_rate;
   assign rx_lane_rate = q.rx_rate;
   assign pll_multiplier_code = q.pll_code;
   assign pll_enable = q.pll_en;
endmodule
`default_nettype wire

// [rtl/lane_cfg_pkg.sv]
// Purpose: Shared constants for the low-side lane configuration block
// Assumes: 32-bit Avalon-MM slave, byte addresses, one word per register
// Notes: Register index times four gives the byte address
package lane_cfg_pkg;

   // Management device address of the configuration space
   localparam logic [4:0] MGMT_DEVICE_ADDR = 5'h1E;
   localparam int NUM_LANES = 4;

   // Register indices and byte addresses
   localparam logic [15:0] PLL_CFG_IDX = 16'h0006;
   localparam logic [15:0] LANE_CFG_IDX = 16'h0007;
   localparam logic [15:0] CTRL_IDX = 16'h0010;
   localparam logic [15:0] STATUS_IDX = 16'h0011;
   localparam logic [7:0] PLL_CFG_ADDR = {PLL_CFG_IDX[5:0], 2'h0};
   localparam logic [7:0] LANE_CFG_ADDR = {LANE_CFG_IDX[5:0], 2'h0};
   localparam logic [7:0] CTRL_ADDR = {CTRL_IDX[5:0], 2'h0};
   localparam logic [7:0] STATUS_ADDR = {STATUS_IDX[5:0], 2'h0};

   // Lane configuration fields
   localparam int SWING_LSB = 12;
   localparam int LOS_BIT = 11;
   localparam int TXEN_BIT = 10;
   localparam int TXRATE_LSB = 8;
   localparam int DE_LSB = 4;
   localparam int RXEN_BIT = 2;
   localparam int RXRATE_LSB = 0;

   // PLL configuration fields
   localparam int MASK_LSB = 12;
   localparam int PLLEN_BIT = 4;
   localparam int MPY_LSB = 0;

   // Control fields
   localparam int CTRL_GPD_BIT = 0;
   localparam int CTRL_OVR_BIT = 1;

   // Reset values
   localparam logic [15:0] LANE_CFG_RST = 16'hDC04;
   localparam logic [15:0] PLL_CFG_RST = 16'hF115;
   localparam logic [1:0] CTRL_RST = 2'h0;

   // Rate and multiplier encodings
   localparam logic [1:0] RATE_FULL = 2'h0;
   localparam logic [1:0] RATE_HALF = 2'h1;
   localparam logic [1:0] RATE_QUARTER = 2'h2;
   localparam logic [3:0] AUTO_PLL_CODE = 4'h5;
   localparam logic [1:0] AUTO_RATE = RATE_FULL;

   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_WORK = 3'b010,
      BUS_DONE = 3'b100
   } bus_state_t;

endpackage

// [rtl/lane_store.sv]
// Purpose: Per-lane configuration words with masked write, registered read
// Assumes: Word width is a whole number of bytes
// Notes: Every selected lane takes the same write data
`timescale 1ns/1ps
`default_nettype none
module lane_store #(
   parameter int LANES = 4,
   parameter int W = 16,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [LANES-1:0] we_lanes,
   input wire logic [W/8-1:0] be,
   input wire logic [W-1:0] wdata,
   input wire logic [$clog2(LANES)-1:0] rd_lane,
   output logic [LANES*W-1:0] words,
   output logic [W-1:0] rdata_q
);
   typedef struct packed {
      logic [LANES-1:0][W-1:0] mem;
      logic [W-1:0] rdata;
   } store_t;

   store_t q;
   store_t d;

   always_comb begin
      d = q;
      for (int i = 0; i < LANES; i++) begin
         for (int b = 0; b < W/8; b++) begin
            if (we_lanes[i] && be[b]) begin
               d.mem[i][b*8 +: 8] = wdata[b*8 +: 8];
            end
         end
      end
      d.rdata = q.mem[rd_lane];
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q.mem <= {LANES{RST}};
         q.rdata <= RST;
      end else begin
         q <= d;
      end
   end

   assign words = q.mem;
   assign rdata_q = q.rdata;
endmodule
`default_nettype wire

// [rtl/code_tables.sv]
// Purpose: Decode swing, de-emphasis and multiplier codes to physical values
// Assumes: Values are typical figures, for status and analog trim tables
// Notes: Amplitude in mV, de-emphasis in hundredths of dB, factor times two
`timescale 1ns/1ps
`default_nettype none
module code_tables (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [2:0] swing,
   input wire logic [3:0] deemph,
   input wire logic [3:0] pll_code,
   output logic [10:0] amp_mv,
   output logic [10:0] deemph_cdb,
   output logic [7:0] pll_x2,
   output logic pll_rsvd
);
   typedef struct packed {
      logic [10:0] amp;
      logic [10:0] de;
      logic [7:0] x2;
      logic rsvd;
   } tab_t;

   tab_t q;
   tab_t d;

   always_comb begin
      d = q;
      case (swing)
         3'h0: d.amp = 11'h0BE;
         3'h1: d.amp = 11'h17C;
         3'h2: d.amp = 11'h230;
         3'h3: d.amp = 11'h2C6;
         3'h4: d.amp = 11'h352;
         3'h5: d.amp = 11'h3B6;
         3'h6: d.amp = 11'h3F2;
         default: d.amp = 11'h41A;
      endcase
      case (deemph)
         4'h0: d.de = 11'h000;
         4'h1: d.de = 11'h02A;
         4'h2: d.de = 11'h057;
         4'h3: d.de = 11'h086;
         4'h4: d.de = 11'h0B7;
         4'h5: d.de = 11'h0EC;
         4'h6: d.de = 11'h124;
         4'h7: d.de = 11'h160;
         4'h8: d.de = 11'h1A0;
         4'h9: d.de = 11'h1E6;
         4'hA: d.de = 11'h231;
         4'hB: d.de = 11'h284;
         4'hC: d.de = 11'h2DF;
         4'hD: d.de = 11'h346;
         4'hE: d.de = 11'h3BA;
         default: d.de = 11'h43F;
      endcase
      d.rsvd = 1'b0;
      case (pll_code)
         4'h0: d.x2 = 8'h08;
         4'h1: d.x2 = 8'h0A;
         4'h2: d.x2 = 8'h0C;
         4'h4: d.x2 = 8'h10;
         4'h5: d.x2 = 8'h14;
         4'h6: d.x2 = 8'h18;
         4'h7: d.x2 = 8'h19;
         4'h8: d.x2 = 8'h1E;
         4'h9: d.x2 = 8'h28;
         4'hA: d.x2 = 8'h32;
         4'hD: d.x2 = 8'h64;
         4'hE: d.x2 = 8'h82;
         default: begin
            d.x2 = 8'h00;
            d.rsvd = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign amp_mv = q.amp;
   assign deemph_cdb = q.de;
   assign pll_x2 = q.x2;
   assign pll_rsvd = q.rsvd;
endmodule
`default_nettype wire

// [dv/lane_cfg_checker.sv]
// Purpose: Port assertions for the lane configuration block
// Assumes: Two wait states per access, one clock domain
// Notes: Decode checks wait for a code held three samples, so lag is not assumed
`timescale 1ns/1ps
`default_nettype none
module lane_cfg_checker (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic channel_powerdown_n,
   input wire logic [3:0] tx_lane_enable,
   input wire logic [3:0] rx_lane_enable,
   input wire logic [11:0] output_amplitude_code,
   input wire logic [15:0] deemphasis_code,
   input wire logic [43:0] output_amplitude_mv,
   input wire logic [43:0] deemphasis_cdb,
   input wire logic [3:0] pll_multiplier_code,
   input wire logic [7:0] pll_factor_x2,
   input wire logic pll_code_reserved
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   localparam logic [7:0] FX2 [16] = '{8'h08, 8'h0A, 8'h0C, 8'h00, 8'h10, 8'h14, 8'h18, 8'h19,
      8'h1E, 8'h28, 8'h32, 8'h00, 8'h00, 8'h64, 8'h82, 8'h00};
   localparam logic [10:0] MV [8] = '{11'h0BE, 11'h17C, 11'h230, 11'h2C6, 11'h352, 11'h3B6,
      11'h3F2, 11'h41A};
   localparam logic [15:0] RSVD = 16'h9808;
   property p_wait_one; !waitrequest |=> waitrequest; endproperty
   a_wait_one: assert property (p_wait_one) else $error("long answer");
   property p_wait_two; $fell(waitrequest) |-> $past(read | write) && $past(read | write, 2);
   endproperty
   a_wait_two: assert property (p_wait_two) else $error("answer without request");
   property p_pd_tx; !channel_powerdown_n [*5] |-> tx_lane_enable == 4'h0; endproperty
   a_pd_tx: assert property (p_pd_tx) else $error("tx on in power-down");
   property p_pd_rx; !channel_powerdown_n [*5] |-> rx_lane_enable == 4'h0; endproperty
   a_pd_rx: assert property (p_pd_rx) else $error("rx on in power-down");
   property p_unmapped;
      read && !waitrequest && !(address inside {8'h18, 8'h1C, 8'h40, 8'h44}) |-> readdata == '0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_factor;
      $past(rstn, 3) && $past(pll_multiplier_code) == pll_multiplier_code
         && $past(pll_multiplier_code, 2) == pll_multiplier_code
         |-> pll_factor_x2 == FX2[pll_multiplier_code];
   endproperty
   a_factor: assert property (p_factor) else $error("bad multiplier factor");
   property p_rsvd;
      $past(rstn, 3) && $past(pll_multiplier_code) == pll_multiplier_code
         && $past(pll_multiplier_code, 2) == pll_multiplier_code
         |-> pll_code_reserved == RSVD[pll_multiplier_code];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("bad reserved flag");
   property p_amp;
      $past(rstn, 3) && $past(output_amplitude_code) == output_amplitude_code
         && $past(output_amplitude_code, 2) == output_amplitude_code
         |-> output_amplitude_mv[10:0] == MV[output_amplitude_code[2:0]];
   endproperty
   a_amp: assert property (p_amp) else $error("bad amplitude");
   property p_deemph;
      $past(rstn, 3) && deemphasis_code[3:0] == 4'hF && $past(deemphasis_code[3:0]) == 4'hF
         && $past(deemphasis_code[3:0], 2) == 4'hF |-> deemphasis_cdb[10:0] == 11'h43F;
   endproperty
   a_deemph: assert property (p_deemph) else $error("bad de-emphasis");
   c_write: cover property (write && !waitrequest);
   c_read: cover property (read && !waitrequest);
   c_pd: cover property (!channel_powerdown_n [*5]);
   c_rsvd: cover property (pll_code_reserved);
endmodule
bind lowside_lane_config lane_cfg_checker chk_i (.clk(clk), .rstn(rstn), .address(address),
   .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
   .channel_powerdown_n(channel_powerdown_n), .tx_lane_enable(tx_lane_enable),
   .rx_lane_enable(rx_lane_enable), .output_amplitude_code(output_amplitude_code),
   .deemphasis_code(deemphasis_code), .output_amplitude_mv(output_amplitude_mv),
   .deemphasis_cdb(deemphasis_cdb), .pll_multiplier_code(pll_multiplier_code),
   .pll_factor_x2(pll_factor_x2), .pll_code_reserved(pll_code_reserved));
`default_nettype wire

// [dv/lowside_lane_config_tb.sv]
// Purpose: Self-checking bench for the lane configuration registers
// Assumes: Outputs settle within four cycles of an answered write
// Notes: Lane mask in the PLL word steers every lane write
`timescale 1ns/1ps
`default_nettype none
module lowside_lane_config_tb;
   logic clk, rstn, read, write, channel_powerdown_n, waitrequest, pll_enable, pll_code_reserved;
   logic [7:0] address, tx_lane_rate, rx_lane_rate, pll_factor_x2;
   logic [31:0] writedata, readdata, rd;
   logic [3:0] byteenable, tx_lane_enable, rx_lane_enable, signal_loss_detect_enable;
   logic [3:0] pll_multiplier_code;
   logic [11:0] output_amplitude_code;
   logic [15:0] deemphasis_code;
   logic [43:0] output_amplitude_mv, deemphasis_cdb;
   localparam logic [15:0] RSVD = 16'h9808;
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   lowside_lane_config dut (.clk(clk), .rstn(rstn), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .channel_powerdown_n(channel_powerdown_n),
      .tx_lane_enable(tx_lane_enable), .rx_lane_enable(rx_lane_enable),
      .signal_loss_detect_enable(signal_loss_detect_enable), .tx_lane_rate(tx_lane_rate),
      .rx_lane_rate(rx_lane_rate), .output_amplitude_code(output_amplitude_code),
      .deemphasis_code(deemphasis_code), .output_amplitude_mv(output_amplitude_mv),
      .deemphasis_cdb(deemphasis_cdb), .pll_multiplier_code(pll_multiplier_code),
      .pll_enable(pll_enable), .pll_factor_x2(pll_factor_x2),
      .pll_code_reserved(pll_code_reserved));
   task automatic chk(input logic [43:0] seen, input logic [43:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Opening edge first, so a release and a new raise never share a time step
   task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
      input logic [3:0] be);
      @(posedge clk);
      address <= a;
      writedata <= {16'h0000, d};
      byteenable <= be;
      read <= !wr;
      write <= wr;
      @(posedge clk);
      while (waitrequest !== 1'h0) @(posedge clk);
      rd = readdata;
      read <= 1'h0;
      write <= 1'h0;
   endtask
   task automatic settle;
      repeat (4) @(posedge clk);
   endtask
   task automatic t_reset;
      bus(1'h0, 8'h1C, 16'h0000, 4'hF);
      chk(rd, 44'hDC04);
      bus(1'h0, 8'h18, 16'h0000, 4'hF);
      chk(rd, 44'hF115);
      chk(output_amplitude_code, 44'hB6D);
      chk(signal_loss_detect_enable, 44'hF);
      chk(deemphasis_code, 44'h0);
      chk({tx_lane_rate, rx_lane_rate}, 44'h0);
      chk(pll_multiplier_code, 44'h5);
      chk(output_amplitude_mv[10:0], 44'h3B6);
   endtask
   task automatic t_mask;
      bus(1'h1, 8'h18, 16'h1115, 4'hF);
      bus(1'h1, 8'h1C, 16'hB6F5, 4'hF);
      bus(1'h0, 8'h1C, 16'h0000, 4'hF);
      chk(rd, 44'hB6F5);
      settle;
      chk(output_amplitude_code, 44'hB6B);
      chk(signal_loss_detect_enable, 44'hE);
      chk(deemphasis_code, 44'hF);
      chk(deemphasis_cdb[10:0], 44'h43F);
      chk({tx_lane_rate, rx_lane_rate}, 44'h0);
      bus(1'h1, 8'h1C, 16'h0000, 4'h1);
      bus(1'h0, 8'h1C, 16'h0000, 4'hF);
      chk(rd, 44'hB600);
      bus(1'h1, 8'h18, 16'h2115, 4'hF);
      bus(1'h0, 8'h1C, 16'h0000, 4'hF);
      chk(rd, 44'hDC04);
   endtask
   task automatic t_override;
      bus(1'h1, 8'h18, 16'h1115, 4'hF);
      bus(1'h1, 8'h1C, 16'hB6F5, 4'hF);
      bus(1'h1, 8'h40, 16'h0002, 4'hF);
      settle;
      chk(tx_lane_rate, 44'h02);
      chk(rx_lane_rate, 44'h01);
      for (int c = 0; c < 16; c++) begin
         bus(1'h1, 8'h18, 16'h1110 | c[15:0], 4'hF);
         settle;
         chk(pll_multiplier_code, c[3:0]);
         chk(pll_code_reserved, RSVD[c]);
         if (c == 14) chk(pll_factor_x2, 44'h82);
      end
      bus(1'h1, 8'h18, 16'h1117, 4'hF);
      bus(1'h1, 8'h40, 16'h0000, 4'hF);
      settle;
      chk(pll_multiplier_code, 44'h5);
      chk({tx_lane_rate, rx_lane_rate}, 44'h0);
   endtask
   task automatic t_power;
      chk({tx_lane_enable, rx_lane_enable, pll_enable}, 44'h1FF);
      channel_powerdown_n <= 1'h0;
      repeat (6) @(posedge clk);
      chk({tx_lane_enable, rx_lane_enable, pll_enable}, 44'h0);
      bus(1'h0, 8'h44, 16'h0000, 4'hF);
      chk(rd, 44'h200);
      channel_powerdown_n <= 1'h1;
      bus(1'h1, 8'h40, 16'h0001, 4'hF);
      settle;
      chk({tx_lane_enable, rx_lane_enable}, 44'h0);
      bus(1'h1, 8'h40, 16'h0000, 4'hF);
      bus(1'h1, 8'h1C, 16'hB2F1, 4'hF);
      settle;
      chk({tx_lane_enable, rx_lane_enable}, 44'hEE);
      bus(1'h1, 8'h44, 16'hFFFF, 4'hF);
      bus(1'h0, 8'h44, 16'h0000, 4'hF);
      chk(rd, 44'hEE);
   endtask
   task automatic t_swing;
      logic [10:0] prev;
      prev = '0;
      for (int c = 0; c < 8; c++) begin
         bus(1'h1, 8'h1C, {1'h1, c[2:0], 12'hC04}, 4'hF);
         settle;
         if (c == 0) chk(output_amplitude_mv[10:0], 44'h0BE);
         else chk(output_amplitude_mv[10:0] > prev, 44'h1);
         prev = output_amplitude_mv[10:0];
      end
      chk(prev, 44'h41A);
      bus(1'h1, 8'h20, 16'hFFFF, 4'hF);
      bus(1'h0, 8'h20, 16'h0000, 4'hF);
      chk(rd, 44'h0);
   endtask
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   initial begin
      rstn = 1'h0;
      read = 1'h0;
      write = 1'h0;
      address = '0;
      writedata = '0;
      byteenable = '0;
      channel_powerdown_n = 1'h1;
      repeat (8) @(posedge clk);
      rstn <= 1'h1;
      t_reset;
      t_mask;
      t_override;
      t_power;
      t_swing;
      final_report;
   end
   // Whole run needs well under two thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         final_report;
      end
   end
endmodule
`default_nettype wire
